//--- core/bsl_pkg.sv
// Package for the board status LED controller: map, fields and timing
package bsl_pkg;

    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned BLINK_SLOW_HZ  = 1;
    localparam int unsigned BLINK_FAST_HZ  = 3;
    // Half periods give the fifty-percent duty cycle
    localparam int unsigned SLOW_HALF_CYC  = CLK_HZ / (2 * BLINK_SLOW_HZ);
    localparam int unsigned FAST_HALF_CYC  = CLK_HZ / (2 * BLINK_FAST_HZ);

    localparam int unsigned NUM_FANS       = 4;
    localparam int unsigned POST_W         = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_FATAL      = 8'h00;
    localparam logic [7:0] ADDR_NONCRIT    = 8'h04;
    localparam logic [7:0] ADDR_BOOT       = 8'h08;
    localparam logic [7:0] ADDR_POST       = 8'h0c;
    localparam logic [7:0] ADDR_FAN_EVT    = 8'h10;
    localparam logic [7:0] ADDR_LED_STAT   = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN     = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_CLR    = 8'h20;
    localparam logic [7:0] ADDR_ADDR_MASK  = 8'hff;

    // Fatal register bit positions
    localparam int unsigned FAT_CPU_CAT    = 0;
    localparam int unsigned FAT_IDMISM     = 1;
    localparam int unsigned FAT_CPU1_MISS  = 2;
    localparam int unsigned FAT_CPU_TRIP   = 3;
    localparam int unsigned FAT_PWR        = 4;
    localparam int unsigned FAT_NO_MEM     = 5;
    localparam int unsigned FAT_UNCORR     = 6;
    localparam int unsigned FAT_DIMM_TRIP  = 7;
    localparam int unsigned FAT_SB_TRIP    = 8;
    localparam int unsigned FAT_ERRPIN     = 9;
    localparam int unsigned FAT_VA240      = 10;
    localparam int unsigned FAT_W          = 11;

    // Non-critical register bit positions
    localparam int unsigned NC_FANS        = 0;
    localparam int unsigned NC_HDD         = 1;
    localparam int unsigned NC_PSU         = 2;
    localparam int unsigned NC_CORR        = 3;
    localparam int unsigned NC_W           = 4;

    // Boot register: write-one command bits
    localparam int unsigned BT_AC_ON       = 0;
    localparam int unsigned BT_FW_UPD      = 1;
    localparam int unsigned BT_COLD_RST    = 2;
    localparam int unsigned BT_WDOG        = 3;
    localparam int unsigned BT_LOADER_DONE = 4;
    localparam int unsigned BT_OS_DONE     = 5;
    localparam int unsigned BT_MEMTEST_BAD = 6;
    localparam int unsigned BT_IMAGES_BAD  = 7;
    localparam int unsigned BT_REARM       = 8;

    // Interrupt status bit positions
    localparam int unsigned IRQ_FATAL      = 0;
    localparam int unsigned IRQ_FAN        = 1;
    localparam int unsigned IRQ_BOOT_DONE  = 2;
    localparam int unsigned IRQ_W          = 3;

    localparam logic [1:0] HTRANS_NONSEQ   = 2'b10;

    typedef enum logic [2:0] {
        BSL_BOOT_OFF,
        BSL_BOOT_LOADER,
        BSL_BOOT_OS,
        BSL_BOOT_DONE,
        BSL_BOOT_DEAD
    } bsl_boot_e;

    typedef enum logic [1:0] {
        BSL_ST_GREEN,
        BSL_ST_GREEN_BLINK,
        BSL_ST_AMBER_BLINK,
        BSL_ST_AMBER
    } bsl_status_e;

    typedef struct packed {
        logic            green;
        logic            amber;
        logic            ident;
        logic            standby;
    } bsl_leds_s;

    typedef struct packed {
        logic            sel;
        logic            write;
        logic [7:0]      addr;
    } bsl_aphase_s;

endpackage

//--- core/bsl_led_ctrl.sv
// Board status LED controller with AHB-Lite register slave
//
// Operation
// - Healthy and booted gives solid green status.
// - Non-critical faults blink amber at 1 Hz.
// - Fatal conditions give solid amber status.
// - AC power-on starts controller boot sequence.
// - Update, cold reset, watchdog restart boot sequence.
// - Memtest or images bad: blue solid, amber.
// - Bootloader: blue blinks 3 Hz, green 1 Hz.
// - OS image stage: blue solid, green solid.
// - Sequence done: identify off, normal indication.
// - Eight LEDs hold last written self-test code.
// - Standby LED lit while standby power present.
// - Fan LED lit on lower-critical threshold event.
// - Fan fault latched until sensor re-arm.
`timescale 1ns/1ps
module bsl_led_ctrl
    import bsl_pkg::*;
#(
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF = FAST_HALF_CYC
)(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                standby_power,
    input  wire logic                dc_power_on,
    input  wire logic [NUM_FANS-1:0] fan_lower_crit,
    output logic                     status_green,
    output logic                     status_amber,
    output logic                     ident_blue,
    output logic                     standby_led,
    output logic      [POST_W-1:0]   post_leds,
    output logic      [NUM_FANS-1:0] fan_leds,
    output logic                     irq
);

    typedef struct packed {
        bsl_aphase_s          ap;
        logic [31:0]          slow_cnt;
        logic [31:0]          fast_cnt;
        logic                 slow_ph;
        logic                 fast_ph;
        logic [FAT_W-1:0]     fatal;
        logic [NC_W-1:0]      noncrit;
        bsl_boot_e            boot;
        logic [POST_W-1:0]    post;
        logic [NUM_FANS-1:0]  fan;
        logic [IRQ_W-1:0]     irq_stat;
        logic [IRQ_W-1:0]     irq_en;
        bsl_leds_s            leds;
        logic [31:0]          rdata;
    } bsl_state_s;

    bsl_state_s s_q;
    bsl_state_s s_d;
    bsl_status_e status;
    logic wr;
    logic [IRQ_W-1:0] evt;

    assign wr = s_q.ap.sel && s_q.ap.write;

    // Most severe condition wins
    always_comb
    begin
        if (|s_q.fatal || s_q.boot == BSL_BOOT_DEAD)
            status = BSL_ST_AMBER;
        else if (|s_q.noncrit)
            status = BSL_ST_AMBER_BLINK;
        else if (s_q.boot == BSL_BOOT_LOADER)
            status = BSL_ST_GREEN_BLINK;
        else
            status = BSL_ST_GREEN;
    end

    always_comb
    begin
        s_d = s_q;
        evt = '0;

        // Blink generators run freely and independently
        if (s_q.slow_cnt >= SLOW_HALF - 1)
        begin
            s_d.slow_cnt = '0;
            s_d.slow_ph  = ~s_q.slow_ph;
        end
        else
            s_d.slow_cnt = s_q.slow_cnt + 32'h1;
        if (s_q.fast_cnt >= FAST_HALF - 1)
        begin
            s_d.fast_cnt = '0;
            s_d.fast_ph  = ~s_q.fast_ph;
        end
        else
            s_d.fast_cnt = s_q.fast_cnt + 32'h1;

        // Address phase capture; one-cycle slave, never waits
        s_d.ap.sel   = hsel && hready && htrans == HTRANS_NONSEQ;
        s_d.ap.write = hwrite;
        s_d.ap.addr  = haddr[7:0] & ADDR_ADDR_MASK;

        if (wr)
        begin
            case (s_q.ap.addr)
                ADDR_FATAL:   s_d.fatal   = hwdata[FAT_W-1:0];
                ADDR_NONCRIT: s_d.noncrit = hwdata[NC_W-1:0];
                ADDR_POST:    s_d.post    = hwdata[POST_W-1:0];
                ADDR_IRQ_EN:  s_d.irq_en  = hwdata[IRQ_W-1:0];
                ADDR_BOOT:
                begin
                    // Dead board stays dead; only a reset leaves it
                    if (s_q.boot != BSL_BOOT_DEAD)
                    begin
                        if (hwdata[BT_MEMTEST_BAD] || hwdata[BT_IMAGES_BAD])
                            s_d.boot = BSL_BOOT_DEAD;
                        else if (hwdata[BT_AC_ON] || hwdata[BT_FW_UPD] ||
                                 hwdata[BT_COLD_RST] || hwdata[BT_WDOG])
                            s_d.boot = BSL_BOOT_LOADER;
                        else if (hwdata[BT_LOADER_DONE] && s_q.boot == BSL_BOOT_LOADER)
                            s_d.boot = BSL_BOOT_OS;
                        else if (hwdata[BT_OS_DONE] && s_q.boot == BSL_BOOT_OS)
                        begin
                            s_d.boot = BSL_BOOT_DONE;
                            evt[IRQ_BOOT_DONE] = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end

        // Fan faults latch; re-arm at DC power-on or by command
        if (dc_power_on || (wr && s_q.ap.addr == ADDR_BOOT && hwdata[BT_REARM]))
            s_d.fan = fan_lower_crit;
        else
            s_d.fan = s_q.fan | fan_lower_crit;

        if (|(fan_lower_crit & ~s_q.fan))
            evt[IRQ_FAN] = 1'b1;
        if (wr && s_q.ap.addr == ADDR_FATAL && |hwdata[FAT_W-1:0] && ~|s_q.fatal)
            evt[IRQ_FATAL] = 1'b1;

        // Set wins over a clear in the same cycle
        if (wr && s_q.ap.addr == ADDR_IRQ_CLR)
            s_d.irq_stat = (s_q.irq_stat & ~hwdata[IRQ_W-1:0]) | evt;
        else
            s_d.irq_stat = s_q.irq_stat | evt;

        // LED drivers
        s_d.leds.standby = standby_power;
        case (status)
            BSL_ST_AMBER:       {s_d.leds.green, s_d.leds.amber} = 2'b01;
            BSL_ST_AMBER_BLINK: {s_d.leds.green, s_d.leds.amber} = {1'b0, s_q.slow_ph};
            BSL_ST_GREEN_BLINK: {s_d.leds.green, s_d.leds.amber} = {s_q.slow_ph, 1'b0};
            default:            {s_d.leds.green, s_d.leds.amber} = 2'b10;
        endcase
        case (s_q.boot)
            BSL_BOOT_LOADER: s_d.leds.ident = s_q.fast_ph;
            BSL_BOOT_OS:     s_d.leds.ident = 1'b1;
            BSL_BOOT_DEAD:   s_d.leds.ident = 1'b1;
            default:         s_d.leds.ident = 1'b0;
        endcase

        // Read data is prepared in the address phase
        s_d.rdata = '0;
        if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite)
        begin
            case (haddr[7:0] & ADDR_ADDR_MASK)
                ADDR_FATAL:    s_d.rdata[FAT_W-1:0]    = s_q.fatal;
                ADDR_NONCRIT:  s_d.rdata[NC_W-1:0]     = s_q.noncrit;
                ADDR_BOOT:     s_d.rdata[$bits(bsl_boot_e)-1:0] = s_q.boot;
                ADDR_POST:     s_d.rdata[POST_W-1:0]   = s_q.post;
                ADDR_FAN_EVT:  s_d.rdata[NUM_FANS-1:0] = s_q.fan;
                ADDR_LED_STAT: s_d.rdata[$bits(bsl_leds_s)-1:0] = s_q.leds;
                ADDR_IRQ_STAT: s_d.rdata[IRQ_W-1:0]    = s_q.irq_stat;
                ADDR_IRQ_EN:   s_d.rdata[IRQ_W-1:0]    = s_q.irq_en;
                default:       s_d.rdata               = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign hrdata       = s_q.rdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign status_green = s_q.leds.green;
    assign status_amber = s_q.leds.amber;
    assign ident_blue   = s_q.leds.ident;
    assign standby_led  = s_q.leds.standby;
    assign post_leds    = s_q.post;
    assign fan_leds     = s_q.fan;
    assign irq          = |(s_q.irq_stat & s_q.irq_en);

    // Checks
    fatal_amber_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (|s_q.fatal) |=> status_amber && !status_green)
        else $error("fatal fault without solid amber");
    va240_amber_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.fatal[FAT_VA240] |=> status_amber)
        else $error("240VA fault without amber");
    noncrit_blink_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (~|s_q.fatal && s_q.boot != BSL_BOOT_DEAD && |s_q.noncrit)
        |=> status_amber == $past(s_q.slow_ph) && !status_green)
        else $error("non-critical fault not blinking amber");
    healthy_green_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (~|s_q.fatal && ~|s_q.noncrit && s_q.boot == BSL_BOOT_DONE)
        |=> status_green && !status_amber && !ident_blue)
        else $error("healthy board not solid green");
    boot_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr && s_q.ap.addr == ADDR_BOOT && hwdata[BT_AC_ON] && s_q.boot != BSL_BOOT_DEAD
         && !hwdata[BT_MEMTEST_BAD] && !hwdata[BT_IMAGES_BAD])
        |=> s_q.boot == BSL_BOOT_LOADER)
        else $error("power-on did not start boot");
    boot_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr && s_q.ap.addr == ADDR_BOOT && (hwdata[BT_WDOG] || hwdata[BT_COLD_RST]
         || hwdata[BT_FW_UPD]) && s_q.boot != BSL_BOOT_DEAD
         && !hwdata[BT_MEMTEST_BAD] && !hwdata[BT_IMAGES_BAD])
        |=> s_q.boot == BSL_BOOT_LOADER)
        else $error("restart cause did not restart boot");
    dead_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr && s_q.ap.addr == ADDR_BOOT && (hwdata[BT_MEMTEST_BAD] || hwdata[BT_IMAGES_BAD]))
        |=> s_q.boot == BSL_BOOT_DEAD)
        else $error("failed self test did not stop boot");
    dead_stays_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.boot == BSL_BOOT_DEAD |=> s_q.boot == BSL_BOOT_DEAD
        ##1 ident_blue && status_amber)
        else $error("non-recoverable state left or wrong LEDs");
    loader_leds_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.boot == BSL_BOOT_LOADER && ~|s_q.fatal && ~|s_q.noncrit)
        |=> ident_blue == $past(s_q.fast_ph) && status_green == $past(s_q.slow_ph))
        else $error("bootloader blink pattern wrong");
    os_leds_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.boot == BSL_BOOT_OS && ~|s_q.fatal && ~|s_q.noncrit)
        |=> ident_blue && status_green)
        else $error("OS stage LEDs wrong");
    ident_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.boot == BSL_BOOT_DONE || s_q.boot == BSL_BOOT_OFF) |=> !ident_blue)
        else $error("identify lit outside boot sequence");
    post_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(wr && s_q.ap.addr == ADDR_POST) |=> $stable(post_leds))
        else $error("self-test code changed without write");
    post_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr && s_q.ap.addr == ADDR_POST) |=> post_leds == $past(hwdata[POST_W-1:0]))
        else $error("self-test code not shown after write");
    standby_lit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        standby_power |=> standby_led)
        else $error("standby LED not lit");
    standby_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !standby_power |=> !standby_led)
        else $error("standby LED lit without standby power");
    fan_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (fan_lower_crit[0] && !dc_power_on) ##1 !dc_power_on
        && !(wr && s_q.ap.addr == ADDR_BOOT && hwdata[BT_REARM])
        |-> fan_leds[0] ##1 fan_leds[0])
        else $error("fan fault not latched");
    // Fan bits may only drop through a re-arm
    fan_held_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!dc_power_on && !(wr && s_q.ap.addr == ADDR_BOOT && hwdata[BT_REARM]))
        |=> (fan_leds & $past(fan_leds)) == $past(fan_leds))
        else $error("fan fault dropped without re-arm");
    fan_rearm_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dc_power_on |=> fan_leds == $past(fan_lower_crit))
        else $error("power-on re-arm did not reload fan faults");
    fan_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (|(fan_lower_crit & ~fan_leds)) |=> s_q.irq_stat[IRQ_FAN])
        else $error("new fan fault lost its status bit");
    fatal_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr && s_q.ap.addr == ADDR_FATAL && |hwdata[FAT_W-1:0] && ~|s_q.fatal)
        |=> s_q.irq_stat[IRQ_FATAL])
        else $error("first fatal fault lost its status bit");
    irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.irq_stat[IRQ_FATAL] && s_q.irq_en[IRQ_FATAL]) |-> irq)
        else $error("enabled status bit without interrupt");
    rdata_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) |=> hrdata == '0)
        else $error("read data driven outside a read data phase");
    blink_half_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(s_q.fast_ph) |=> !$changed(s_q.fast_ph))
        else $error("fast blink phase toggled twice");
    slow_span_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.slow_cnt < SLOW_HALF)
        else $error("slow blink counter overran its half period");

    loader_c: cover property (@(posedge hclk) disable iff (!hresetn)
        s_q.boot == BSL_BOOT_LOADER ##1 s_q.boot == BSL_BOOT_OS);
    done_c:   cover property (@(posedge hclk) disable iff (!hresetn)
        s_q.boot == BSL_BOOT_DONE && status_green);
    fan_c:    cover property (@(posedge hclk) disable iff (!hresetn) |fan_leds);
    irq_c:    cover property (@(posedge hclk) disable iff (!hresetn) irq);

endmodule

//--- dv/bsl_sensor_model.sv
// Sensor and power side model: fan tach events, standby and DC power
`timescale 1ns/1ps
module bsl_sensor_model
    import bsl_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic [NUM_FANS-1:0] fan_req,
    input  wire logic                stby_req,
    input  wire logic                dc_req,
    output logic      [NUM_FANS-1:0] fan_lower_crit,
    output logic                     standby_power,
    output logic                     dc_power_on
);
    // Levels move just after an edge, like a polled sensor
    always_ff @(posedge hclk)
    begin
        fan_lower_crit <= fan_req;
        standby_power  <= stby_req;
        dc_power_on    <= dc_req;
    end
endmodule

//--- dv/test_board_status_led_controller.sv
// Self-checking bench for the board status LED controller
`timescale 1ns/1ps
module test_board_status_led_controller
    import bsl_pkg::*;
;
    localparam int SLOW = 4;
    localparam int FAST = 2;
    localparam int WIN  = 24;
    logic                hclk = 1'b0;
    logic                hresetn;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    logic                stby_req;
    logic                dc_req;
    logic [NUM_FANS-1:0] fan_req;
    logic                standby_power;
    logic                dc_power_on;
    logic [NUM_FANS-1:0] fan_lower_crit;
    logic                status_green;
    logic                status_amber;
    logic                ident_blue;
    logic                standby_led;
    logic [POST_W-1:0]   post_leds;
    logic [NUM_FANS-1:0] fan_leds;
    logic                irq;
    logic [31:0]         rd_q;
    int                  n_fail;
    int                  compares;
    int                  causes[3];
    int                  dead[2];

    always #25 hclk = ~hclk;
    // Captures the data phase value as it stood before the edge
    always @(posedge hclk) rd_q <= hrdata;

    bsl_led_ctrl #(.SLOW_HALF(SLOW), .FAST_HALF(FAST)) i_bsl_led_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .standby_power(standby_power), .dc_power_on(dc_power_on),
        .fan_lower_crit(fan_lower_crit), .status_green(status_green),
        .status_amber(status_amber), .ident_blue(ident_blue),
        .standby_led(standby_led), .post_leds(post_leds), .fan_leds(fan_leds),
        .irq(irq));

    bsl_sensor_model i_bsl_sensor_model (
        .hclk(hclk), .fan_req(fan_req), .stby_req(stby_req), .dc_req(dc_req),
        .fan_lower_crit(fan_lower_crit), .standby_power(standby_power),
        .dc_power_on(dc_power_on));

    task automatic conclude;
        if (n_fail == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        #1;
        rd = rd_q;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(v, exp);
        chk(hresp, 1'b0);
    endtask

    // Order is green, amber, identify, standby
    task automatic leds(input logic [3:0] exp);
        chk({28'h0, status_green, status_amber, ident_blue, standby_led}, {28'h0, exp});
    endtask

    // Edge counts over a whole number of half periods are phase independent
    task automatic blink(input int eg, input int ea, input int eb);
        int         ng = 0;
        int         na = 0;
        int         nb = 0;
        logic [2:0] p;
        p = {status_green, status_amber, ident_blue};
        repeat (WIN)
        begin
            cyc(1);
            ng += int'(status_green !== p[2]);
            na += int'(status_amber !== p[1]);
            nb += int'(ident_blue !== p[0]);
            p = {status_green, status_amber, ident_blue};
        end
        chk(ng, eg);
        chk(na, ea);
        chk(nb, eb);
    endtask

    task automatic do_reset;
        hresetn <= 1'b0;
        cyc(20);
        hresetn <= 1'b1;
        cyc(2);
    endtask

    task automatic boot_to_done;
        wr(ADDR_BOOT, 32'h1 << BT_LOADER_DONE);
        wr(ADDR_BOOT, 32'h1 << BT_OS_DONE);
        cyc(3);
    endtask

    initial
    begin
        {hsel, hwrite, stby_req, dc_req} = 4'h0;
        haddr = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        hwdata = 32'h0;
        fan_req = '0;
        n_fail = 0;
        compares = 0;
        causes = '{BT_FW_UPD, BT_COLD_RST, BT_WDOG};
        dead = '{BT_MEMTEST_BAD, BT_IMAGES_BAD};
        do_reset();
        leds(4'b1000);
        stby_req <= 1'b1;
        cyc(3);
        leds(4'b1001);
        stby_req <= 1'b0;
        cyc(3);
        leds(4'b1000);
        wr(ADDR_POST, 32'ha5);
        cyc(2);
        chk(post_leds, 8'ha5);
        wr(ADDR_POST, 32'h3c);
        cyc(2);
        chk(post_leds, 8'h3c);
        rdchk(ADDR_POST, 32'h3c);
        rdchk(ADDR_BOOT, 32'h0);
        wr(ADDR_BOOT, 32'h1 << BT_AC_ON);
        rdchk(ADDR_BOOT, 32'h1);
        cyc(2);
        blink(WIN / SLOW, 0, WIN / FAST);
        wr(ADDR_BOOT, 32'h1 << BT_LOADER_DONE);
        cyc(3);
        leds(4'b1010);
        blink(0, 0, 0);
        wr(ADDR_BOOT, 32'h1 << BT_OS_DONE);
        cyc(3);
        leds(4'b1000);
        rdchk(ADDR_BOOT, 32'h3);
        foreach (causes[i])
        begin
            wr(ADDR_BOOT, 32'h1 << causes[i]);
            rdchk(ADDR_BOOT, 32'h1);
            boot_to_done();
        end
        rdchk(ADDR_IRQ_STAT, 32'h4);
        chk(irq, 1'b0);
        wr(ADDR_IRQ_EN, 32'h7);
        rdchk(ADDR_IRQ_EN, 32'h7);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_CLR, 32'h4);
        cyc(1);
        chk(irq, 1'b0);
        for (int i = 0; i < NC_W; i++)
        begin
            wr(ADDR_NONCRIT, 32'h1 << i);
            cyc(3);
            blink(0, WIN / SLOW, 0);
            chk({status_green, ident_blue}, 2'b00);
        end
        wr(ADDR_BOOT, 32'h1 << BT_AC_ON);
        cyc(3);
        blink(0, WIN / SLOW, WIN / FAST);
        boot_to_done();
        wr(ADDR_IRQ_CLR, 32'h4);
        for (int i = 0; i < FAT_W; i++)
        begin
            wr(ADDR_FATAL, 32'h1 << i);
            cyc(3);
            leds(4'b0100);
            chk(irq, 1'b1);
            wr(ADDR_IRQ_CLR, 32'h1);
            wr(ADDR_FATAL, 32'h0);
            cyc(1);
            chk(irq, 1'b0);
        end
        wr(ADDR_NONCRIT, 32'h0);
        fan_req <= 4'b0100;
        cyc(3);
        chk(fan_leds, 4'b0100);
        chk(irq, 1'b1);
        rdchk(ADDR_FAN_EVT, 32'h4);
        fan_req <= 4'b0000;
        cyc(3);
        chk(fan_leds, 4'b0100);
        wr(ADDR_BOOT, 32'h1 << BT_REARM);
        cyc(3);
        chk(fan_leds, 4'b0000);
        fan_req <= 4'b1001;
        cyc(3);
        fan_req <= 4'b0001;
        dc_req <= 1'b1;
        cyc(3);
        dc_req <= 1'b0;
        cyc(2);
        chk(fan_leds, 4'b0001);
        rdchk(8'h40, 32'h0);
        wr(ADDR_LED_STAT, 32'hffffffff);
        rdchk(ADDR_LED_STAT, 32'h8);
        foreach (dead[i])
        begin
            do_reset();
            wr(ADDR_BOOT, 32'h1 << BT_AC_ON);
            wr(ADDR_BOOT, 32'h1 << dead[i]);
            wr(ADDR_BOOT, 32'h1 << BT_AC_ON);
            cyc(3);
            leds(4'b0110);
            rdchk(ADDR_BOOT, 32'h4);
            blink(0, 0, 0);
        end
        conclude();
    end

    // Whole sequence needs well under a thousand cycles
    initial
    begin
        #(50 * 20000);
        n_fail++;
        conclude();
    end
endmodule
